// ---- hw/pwmcc_consts.svh ----
// Register indices, field positions, reset values and bus widths
`ifndef PWMCC_CONSTS_SVH
`define PWMCC_CONSTS_SVH
`define PWMCC_ADR_W 8
`define PWMCC_DAT_W 32
`define PWMCC_IDX_EN 6'h00
`define PWMCC_IDX_POL 6'h01
`define PWMCC_IDX_CLK 6'h02
`define PWMCC_IDX_PRCLK 6'h03
`define PWMCC_IDX_CAE 6'h04
`define PWMCC_IDX_CTL 6'h05
`define PWMCC_IDX_SCLA 6'h08
`define PWMCC_IDX_SCLB 6'h09
`define PWMCC_IDX_CNT0 6'h0C
`define PWMCC_IDX_PER0 6'h12
`define PWMCC_IDX_DTY0 6'h18
`define PWMCC_PCKA_LSB 0
`define PWMCC_PCKB_LSB 4
`define PWMCC_PRCLK_MASK 8'h77
`define PWMCC_CTL_MASK 8'h30
`define PWMCC_CON01_BIT 4
`define PWMCC_RST_BYTE 8'h00
`define PWMCC_RST_PER 8'hFF
`define PWMCC_SCALE_FULL 10'h200
`endif

// ---- hw/pwmcc_pkg.sv ----
// Types shared by the configuration block and its channels
package pwmcc_pkg;
  typedef struct packed {
    logic en;
    logic pol;
    logic cae;
    logic tick;
    logic [15:0] per;
    logic [15:0] dty;
  } pwmcc_chcfg_t;
  typedef enum logic [0:0] {
    PWMCC_UP = 1'b0,
    PWMCC_DOWN = 1'b1
  } pwmcc_dir_t;
endpackage : pwmcc_pkg

// ---- hw/pwmcc_clkgen.sv ----
// Prescaler and scalers producing clock A/B and scaled clock A/B enables
`timescale 1ns/1ns
`default_nettype none
`include "pwmcc_consts.svh"
module pwmcc_clkgen (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [2:0] sel_a,
  input wire logic [2:0] sel_b,
  input wire logic [7:0] scl_a,
  input wire logic [7:0] scl_b,
  input wire logic load_a,
  input wire logic load_b,
  output logic tick_a,
  output logic tick_b,
  output logic tick_sa,
  output logic tick_sb
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [6:0] pre_mask(input logic [2:0] sel);
    pre_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction : pre_mask

  // Zero scale counts as full scale
  function automatic logic [9:0] scale_lim(input logic [7:0] n);
    scale_lim = (n == 8'h00) ? `PWMCC_SCALE_FULL : {1'b0, n, 1'b0};
  endfunction : scale_lim

  logic [6:0] pre_r;
  logic [9:0] sca_r;
  logic [9:0] scb_r;
  wire [6:0] mask_a = pre_mask(sel_a);
  wire [6:0] mask_b = pre_mask(sel_b);
  wire [9:0] lim_a = scale_lim(scl_a);
  wire [9:0] lim_b = scale_lim(scl_b);

  // ------------------------------------------------------------
  // Dividers
  // ------------------------------------------------------------
  // Shared counter: a new select takes effect at once, may cut a pulse
  assign tick_a = run && ((pre_r & mask_a) == mask_a);
  assign tick_b = run && ((pre_r & mask_b) == mask_b);
  assign tick_sa = tick_a && (sca_r == lim_a - 10'h001);
  assign tick_sb = tick_b && (scb_r == lim_b - 10'h001);

  // Prescaler stops while no enable bit is set, saving power
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !run) begin
      pre_r <= 7'h00;
    end else begin
      pre_r <= pre_r + 7'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || load_a || tick_sa) begin
      sca_r <= 10'h000;
    end else if (tick_a) begin
      sca_r <= sca_r + 10'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || load_b || tick_sb) begin
      scb_r <= 10'h000;
    end else if (tick_b) begin
      scb_r <= scb_r + 10'h001;
    end
  end

  div2_spacing_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tick_a && sel_a == 3'h1 && !load_a |=> !tick_a)
    else $error("clock A ticked twice in a row at divide by 2");
  scaled_sub_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tick_sa |-> tick_a && sca_r == lim_a - 10'h001)
    else $error("scaled clock A not aligned to clock A");
endmodule : pwmcc_clkgen
`default_nettype wire

// ---- hw/pwmcc_chan.sv ----
// One waveform channel: counter and output level
`timescale 1ns/1ns
`default_nettype none
module pwmcc_chan (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire pwmcc_pkg::pwmcc_chcfg_t cfg,
  output logic lvl,
  output logic [15:0] cnt
);
  import pwmcc_pkg::*;
  logic run_r;
  logic [15:0] cnt_r;
  pwmcc_dir_t dir_r;
  wire at_top = (cnt_r >= cfg.per - 16'h0001) || (cfg.per == 16'h0000);

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  // Waveform waits for the selected clock's next tick after enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !cfg.en) begin
      run_r <= 1'b0;
      cnt_r <= 16'h0000;
      dir_r <= PWMCC_UP;
    end else if (cfg.tick) begin
      run_r <= 1'b1;
      if (!run_r) begin
        cnt_r <= 16'h0000;
      end else if (!cfg.cae) begin
        cnt_r <= at_top ? 16'h0000 : cnt_r + 16'h0001;
      end else if (dir_r == PWMCC_UP) begin
        if (cnt_r >= cfg.per) begin
          dir_r <= PWMCC_DOWN;
          cnt_r <= (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end else if (cnt_r == 16'h0000) begin
        dir_r <= PWMCC_UP;
        cnt_r <= (cfg.per == 16'h0000) ? 16'h0000 : 16'h0001;
      end else begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  // Centre mode keeps the start level on the way down at duty, so both halves match
  wire hold_down = cfg.cae && (dir_r == PWMCC_DOWN) && (cnt_r == cfg.dty) && (cfg.dty != 16'h0000);
  // Start level until duty is reached; polarity applies at once
  assign lvl = (run_r && cnt_r >= cfg.dty && !hold_down) ? ~cfg.pol : cfg.pol;
  assign cnt = cnt_r;

  start_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    run_r && cfg.pol && cnt_r < cfg.dty |-> lvl)
    else $error("start level not high");
  start_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    run_r && !cfg.pol && cnt_r >= cfg.dty && !hold_down |-> lvl)
    else $error("level not high after duty");
  left_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    run_r && cfg.en && cfg.tick && !cfg.cae && at_top |=> cnt_r == 16'h0000)
    else $error("left aligned counter did not wrap");
  center_turn_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    run_r && cfg.en && cfg.tick && cfg.cae && dir_r == PWMCC_UP && cnt_r >= cfg.per
    |=> dir_r == PWMCC_DOWN)
    else $error("center aligned counter did not turn");
  wait_tick_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !run_r && !cfg.tick |=> !run_r)
    else $error("waveform started without a clock tick");
endmodule : pwmcc_chan
`default_nettype wire

// ---- hw/pwmcc_top.sv ----
// Four-channel waveform configuration block with Wishbone registers
`timescale 1ns/1ns
`default_nettype none
`include "pwmcc_consts.svh"
module pwmcc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PWMCC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [`PWMCC_DAT_W-1:0] wb_dat_i,
  output logic [`PWMCC_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_oe
);
  import pwmcc_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdat_r;
  logic [3:0] en_r;
  logic [3:0] pol_r;
  logic [3:0] csel_r;
  logic [3:0] cae_r;
  logic [7:0] prclk_r;
  logic [7:0] ctl_r;
  logic [7:0] scla_r;
  logic [7:0] sclb_r;
  logic [7:0] per_r [4];
  logic [7:0] dty_r [4];
  logic [3:0] out_r;
  logic [3:0] oe_r;
  logic [7:0] rd_byte;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire [5:0] idx = wb_adr_i[7:2];
  wire aligned = (wb_adr_i[1:0] == 2'h0);
  wire wr = req && wb_we_i && wb_sel_i[0] && aligned;
  wire [7:0] wd = wb_dat_i[7:0];
  wire wr_en = wr && (idx == `PWMCC_IDX_EN);
  wire wr_pol = wr && (idx == `PWMCC_IDX_POL);
  wire wr_clk = wr && (idx == `PWMCC_IDX_CLK);
  wire wr_prclk = wr && (idx == `PWMCC_IDX_PRCLK);
  wire wr_cae = wr && (idx == `PWMCC_IDX_CAE);
  wire wr_ctl = wr && (idx == `PWMCC_IDX_CTL);
  wire wr_scla = wr && (idx == `PWMCC_IDX_SCLA);
  wire wr_sclb = wr && (idx == `PWMCC_IDX_SCLB);
  wire [5:0] per_off = idx - `PWMCC_IDX_PER0;
  wire [5:0] dty_off = idx - `PWMCC_IDX_DTY0;
  wire [5:0] cnt_off = idx - `PWMCC_IDX_CNT0;
  wire per_hit = (idx >= `PWMCC_IDX_PER0) && (per_off < 6'h04);
  wire dty_hit = (idx >= `PWMCC_IDX_DTY0) && (dty_off < 6'h04);
  wire cnt_hit = (idx >= `PWMCC_IDX_CNT0) && (cnt_off < 6'h04);

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // All configuration bytes take writes at any time
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_r <= 4'h0;
      pol_r <= 4'h0;
      csel_r <= 4'h0;
      cae_r <= 4'h0;
      prclk_r <= `PWMCC_RST_BYTE;
      ctl_r <= `PWMCC_RST_BYTE;
      scla_r <= `PWMCC_RST_BYTE;
      sclb_r <= `PWMCC_RST_BYTE;
    end else begin
      if (wr_en) en_r <= wd[3:0];
      if (wr_pol) pol_r <= wd[3:0];
      if (wr_clk) csel_r <= wd[3:0];
      if (wr_prclk) prclk_r <= wd & `PWMCC_PRCLK_MASK;
      if (wr_cae) cae_r <= wd[3:0];
      if (wr_ctl) ctl_r <= wd & `PWMCC_CTL_MASK;
      if (wr_scla) scla_r <= wd;
      if (wr_sclb) sclb_r <= wd;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (sys_rst) begin
        per_r[i] <= `PWMCC_RST_PER;
        dty_r[i] <= `PWMCC_RST_PER;
      end else begin
        if (wr && per_hit && per_off[1:0] == 2'(i)) per_r[i] <= wd;
        if (wr && dty_hit && dty_off[1:0] == 2'(i)) dty_r[i] <= wd;
      end
    end
  end

  // ------------------------------------------------------------
  // Clock generation
  // ------------------------------------------------------------
  logic tick_a;
  logic tick_b;
  logic tick_sa;
  logic tick_sb;

  pwmcc_clkgen u_clkgen (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(|en_r),
    .sel_a(prclk_r[`PWMCC_PCKA_LSB +: 3]),
    .sel_b(prclk_r[`PWMCC_PCKB_LSB +: 3]),
    .scl_a(scla_r),
    .scl_b(sclb_r),
    .load_a(wr_scla),
    .load_b(wr_sclb),
    .tick_a(tick_a),
    .tick_b(tick_b),
    .tick_sa(tick_sa),
    .tick_sb(tick_sb)
  );

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  pwmcc_chcfg_t cfg [4];
  logic [3:0] lvl;
  logic [15:0] cnt [4];
  logic [3:0] pin_en;

  for (genvar i = 0; i < 4; i++) begin : g_ch
    localparam bit UPPER = (i % 2) == 1;
    localparam bit BANK_A = i < 2;
    wire join_pair = ctl_r[`PWMCC_CON01_BIT + i / 2];
    wire plain = BANK_A ? tick_a : tick_b;
    wire scaled = BANK_A ? tick_sa : tick_sb;
    // Joined lower channel is silenced; upper one runs 16 bits
    assign pin_en[i] = en_r[i] && !(join_pair && !UPPER);
    assign cfg[i].en = pin_en[i];
    assign cfg[i].pol = pol_r[i];
    assign cfg[i].cae = cae_r[i];
    assign cfg[i].tick = csel_r[i] ? scaled : plain;
    assign cfg[i].per = (UPPER && join_pair) ? {per_r[i ^ 1], per_r[i]} : {8'h00, per_r[i]};
    assign cfg[i].dty = (UPPER && join_pair) ? {dty_r[i ^ 1], dty_r[i]} : {8'h00, dty_r[i]};

    pwmcc_chan u_chan (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cfg(cfg[i]),
      .lvl(lvl[i]),
      .cnt(cnt[i])
    );
  end

  // Pin drives as soon as enabled, before the first tick
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_r <= 4'h0;
      oe_r <= 4'h0;
    end else begin
      out_r <= lvl & pin_en;
      oe_r <= pin_en;
    end
  end

  // ------------------------------------------------------------
  // Read path and acknowledge
  // ------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (aligned) begin
      unique case (1'b1)
        idx == `PWMCC_IDX_EN: rd_byte = {4'h0, en_r};
        idx == `PWMCC_IDX_POL: rd_byte = {4'h0, pol_r};
        idx == `PWMCC_IDX_CLK: rd_byte = {4'h0, csel_r};
        idx == `PWMCC_IDX_PRCLK: rd_byte = prclk_r;
        idx == `PWMCC_IDX_CAE: rd_byte = {4'h0, cae_r};
        idx == `PWMCC_IDX_CTL: rd_byte = ctl_r;
        idx == `PWMCC_IDX_SCLA: rd_byte = scla_r;
        idx == `PWMCC_IDX_SCLB: rd_byte = sclb_r;
        per_hit: rd_byte = per_r[per_off[1:0]];
        dty_hit: rd_byte = dty_r[dty_off[1:0]];
        cnt_hit: rd_byte = cnt[cnt_off[1:0]][7:0];
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Unmapped addresses still ack, reading zero; one wait state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      rdat_r <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign pwm_out = out_r;
  assign pwm_oe = oe_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  pol_readback_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_pol ##[1:3] req && !wb_we_i && aligned && idx == `PWMCC_IDX_POL
    |=> wb_dat_o[3:0] == $past(pol_r))
    else $error("start level readback mismatch");
  bank_b_src_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cfg[2].tick |-> (csel_r[2] ? tick_sb : tick_b))
    else $error("channel 2 ticked from wrong clock");
  joined_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctl_r[5] |=> !pwm_oe[2])
    else $error("joined lower pin still enabled");
  enable_now_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en && wd[1] && !ctl_r[4] ##1 en_r[1] |=> pwm_oe[1])
    else $error("enable did not drive pin at once");
endmodule : pwmcc_top
`default_nettype wire

// ---- test/pwmcc_tb.sv ----
// Self-checking bench for the four-channel waveform configuration block
`timescale 1ns/1ns
`default_nettype none
`include "pwmcc_consts.svh"
module testbench;
  import pwmcc_pkg::*;
  logic sys_clk;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [`PWMCC_ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [`PWMCC_DAT_W-1:0] wb_dat_i = 32'h00000000;
  logic [`PWMCC_DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] pwm_out;
  logic [3:0] pwm_oe;
  int num_errors = 0;
  int n_checks = 0;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr_r = 32'h000106B5;
  logic [5:0] reg_idx[4] = '{6'h01, 6'h02, 6'h03, 6'h04};
  logic [7:0] reg_mask[4] = '{8'h0F, 8'h0F, 8'h77, 8'h0F};

  pwmcc_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_out(pwm_out), .pwm_oe(pwm_oe));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // Request held until ack is sampled, then released for at least a cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, dat};
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 100) check_val("bus ack", 32'h00000001, 32'h00000000);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
    wb_xfer(1'b1, {idx, 2'b00}, dat);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    exp_q.push_back(exp);
    wb_xfer(1'b0, adr, 8'h00);
  endtask : rd

  // Read results are judged where they appear, oldest note first
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) check_val("unexpected read", 32'h00000000, 32'hFFFFFFFF);
      else check_val("read data", {24'h000000, exp_q.pop_front()}, wb_dat_o);
    end
  end

  // First entry may land mid pulse, so timing starts from the second entry
  task automatic measure(input int ch, input logic pol, input int exp_per, input int exp_act);
    int n;
    int act;
    int per;
    n = 0;
    act = 0;
    per = 0;
    repeat (2) begin
      while (pwm_out[ch] === pol && n < 20000) begin @(posedge sys_clk); n++; end
      while (pwm_out[ch] !== pol && n < 20000) begin @(posedge sys_clk); n++; end
    end
    while (pwm_out[ch] === pol && per < 20000) begin @(posedge sys_clk); act++; per++; end
    while (pwm_out[ch] !== pol && per < 20000) begin @(posedge sys_clk); per++; end
    check_val("start level cycles", 32'(exp_act), 32'(act));
    check_val("period cycles", 32'(exp_per), 32'(per));
  endtask : measure

  // Period 4, duty 2; the unused prescale side and scaler differ to expose a wrong source
  task automatic run_case(input int ch, input logic [2:0] k, input logic sel, input logic cae,
                          input logic pol, input logic [7:0] scl);
    int mult;
    mult = (1 << k) * (sel ? 2 * ((scl == 8'h00) ? 256 : int'(scl)) : 1);
    wr(`PWMCC_IDX_EN, 8'h00);
    wr(`PWMCC_IDX_PRCLK, (ch < 2) ? {1'b0, k ^ 3'h1, 1'b0, k} : {1'b0, k, 1'b0, k ^ 3'h1});
    wr(`PWMCC_IDX_SCLA, (ch < 2) ? scl : scl + 8'h01);
    wr(`PWMCC_IDX_SCLB, (ch < 2) ? scl + 8'h01 : scl);
    wr(`PWMCC_IDX_CLK, {4'h0, {4{sel}}});
    wr(`PWMCC_IDX_CAE, {4'h0, {4{cae}}});
    wr(`PWMCC_IDX_POL, {4'h0, {4{pol}}});
    wr(`PWMCC_IDX_PER0 + 6'(ch), 8'h04);
    wr(`PWMCC_IDX_DTY0 + 6'(ch), 8'h02);
    wr(`PWMCC_IDX_EN, 8'(1 << ch));
    @(posedge sys_clk);
    check_val("pin enables", 32'(1 << ch), {28'h0000000, pwm_oe});
    measure(ch, pol, (cae ? 8 : 4) * mult, (cae ? 4 : 2) * mult);
  endtask : run_case

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check_val("pins after reset", 32'h00000000, {24'h000000, pwm_oe, pwm_out});
    for (int i = 0; i < 4; i++) rd({reg_idx[i], 2'b00}, 8'h00);
    for (int i = 0; i < 12; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      wr(reg_idx[i % 4], lfsr_r[7:0]);
      rd({reg_idx[i % 4], 2'b00}, lfsr_r[7:0] & reg_mask[i % 4]);
    end
    wr(6'h06, lfsr_r[15:8]);
    rd(8'h18, 8'h00);
    exp_q.push_back(8'h00);
    wb_xfer(1'b0, 8'h05, 8'h00);
    for (int c = 0; c < 8; c++) begin
      run_case(c % 4, 3'(c), (c < 4) & c[0], c[1], c[0] ^ c[2], 8'h02);
    end
    run_case(1, 3'h0, 1'b1, 1'b0, 1'b1, 8'h00);
    run_case(0, 3'h1, 1'b0, 1'b0, 1'b1, 8'h02);
    // Live change of start level, clock choice and prescale on a running channel
    wr(`PWMCC_IDX_CLK, 8'h01);
    wr(`PWMCC_IDX_POL, 8'h00);
    wr(`PWMCC_IDX_PRCLK, 8'h02);
    measure(0, 1'b0, 64, 32);
    wr(`PWMCC_IDX_EN, 8'h00);
    wr(`PWMCC_IDX_CTL, 8'h20);
    wr(`PWMCC_IDX_EN, 8'h0C);
    @(posedge sys_clk);
    check_val("joined pin enables", 32'h00000008, {28'h0000000, pwm_oe});
    rd(8'h14, 8'h20);
    test_done();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done();
  end
endmodule : testbench
`default_nettype wire
